// *** inc/shp_pkg.sv ***
// Purpose: shared constants of the slave host port
// Assumes: one 40 MHz clock, all pins synchronous to it
// Notes:   status layout and opcodes of the embedded controller
package shp_pkg;
   // instruction opcodes seen on the internal cpu side
   localparam logic [7:0] OP_STATUS_MOVE = 8'h90;
   localparam logic [7:0] OP_EN_DMA      = 8'he5;
   localparam logic [7:0] OP_GATE_EN     = 8'h33;
   localparam logic [7:0] OP_EN_FLAGS    = 8'hf4;   // value arbitrary, not fixed elsewhere
   // gate line command bytes
   localparam logic [7:0] CMD_WRITE_OUT  = 8'hd1;
   localparam logic [7:0] CMD_NULL       = 8'hff;
   // host_status field positions
   localparam int ST_OBF  = 0;
   localparam int ST_IBF  = 1;
   localparam int ST_F0   = 2;
   localparam int ST_CMD  = 3;
   localparam int ST_USR  = 4;
   // port 2 bit positions
   localparam int P2_GATE = 1;
   localparam int P2_OBF  = 4;
   localparam int P2_IBF  = 5;
   localparam int P2_DRQ  = 6;
   localparam int P2_DMA_ACKNOWLEDGE_IN = 7;
   // reset values and sizes
   localparam logic [7:0] P2_RESET   = 8'hff;
   localparam logic [3:0] USR_RESET  = 4'h0;
   localparam int         FIFO_DEPTH = 16;
   localparam int         FIFO_WIDTH = 9;          // command flag plus byte
endpackage

// *** core/shp_host_port.sv ***
// Purpose: host side byte buffers, status, flag pins, dma handshake, gate line
// Assumes: host strobes and pins already synchronous to clk_sys
// Notes:   input byte path runs through a 16 entry fifo toward the cpu
//
// Notes on behaviour
// (R1) separate host input buffer and host output buffer
// (R2) status move opcode 90h copies accumulator bits 4-7, bits 0-3 kept
// (R3) buffer flags update only after the trailing edge of a host strobe
// (R4) cpu status changes held back while host reads status; code holds user bits and output-full, not input-full
// (R5) port 2 bits 4,5 plain port until flag-enable instruction
// (R6) flags on: bit4 written 1 follows output-full, written 0 stays low
// (R7) flags on: bit5 written 1 shows inverse input-full, 0 stays low
// (R8) port 2 bits 6,7 plain until dma-enable opcode 0e5h
// (R9) dma on: writing 1 to port 2 bit 6 raises dma request
// (R10) request drops on ack with host strobe or repeated dma-enable
// (R11) dma acknowledge selects the data buffers in place of chip select
// (R12) gate logic stays on after its enable until reset
// (R13) gate on: port 2 bit 1 readable output, changed only by d1 sequence
// (R14) command d1h then data byte sets gate pin with no cpu work
// (R15) only data bit 1 of the sequence data is copied to the pin
// (R16) input-full never set during a valid gate sequence
// (R17) ffh after valid sequence leaves input-full clear, else acts normally
// (R18) d1h then another command: both later writes set input-full, pin kept
// (R19) gate pin holds during command writes, changes on data write
// (R20) gate enable decoded from opcode 33h
// (R21) select high marks a command byte, command flag records last kind; code leaves the flag unchanged on d1h, gate data and trailing ffh writes
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module shp_fifo #(
   parameter int W = 9,
   parameter int D = 16
) (
   input  wire logic         clk_sys,    // system clock
   input  wire logic         reset_n,    // async reset, active low
   input  wire logic         in_valid,   // write request
   output logic              in_ready,   // room available
   input  wire logic [W-1:0] in_data,    // write word
   output logic              out_valid,  // word available
   input  wire logic         out_ready,  // reader takes word
   output logic [W-1:0]      out_data    // head word
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0]   count;
   } shp_fifo_st_t;

   shp_fifo_st_t   st_reg;
   shp_fifo_st_t   st_next;
   logic [W-1:0]   mem [D];
   logic           do_push;
   logic           do_pop;

   assign in_ready  = (st_reg.count != (AW+1)'(D));
   assign out_valid = (st_reg.count != '0);
   assign out_data  = mem[st_reg.rd_ptr];
   assign do_push   = in_valid & in_ready;
   assign do_pop    = out_valid & out_ready;

   always_comb begin
      st_next = st_reg;
      if (do_push) begin
         st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
      end
      if (do_pop) begin
         st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
      end
      case ({do_push, do_pop})
         2'b10:   st_next.count = st_reg.count + 1'b1;
         2'b01:   st_next.count = st_reg.count - 1'b1;
         default: st_next.count = st_reg.count;
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // storage carries no reset, only pointers and count do
   always_ff @(posedge clk_sys) begin
      if (do_push) begin
         mem[st_reg.wr_ptr] <= in_data;
      end
   end
endmodule // shp_fifo

////////////////////////////////////////////////////////////////////////////////
module shp_host_port (
   input  wire logic       clk_sys,        // system clock, 40 MHz
   input  wire logic       reset_n,        // async reset, active low
   // host bus
   input  wire logic       cs_n,           // chip select, active low
   input  wire logic       rd_n,           // host read strobe, active low
   input  wire logic       wr_n,           // host write strobe, active low
   input  wire logic       command_data_select, // 1 command or status, 0 data
   input  wire logic [7:0] host_din,       // host write data
   output logic [7:0]      host_dout,      // host read data
   output logic            host_dout_oe,   // high while driving the data bus
   output logic            host_in_ready,  // input fifo has room
   // internal cpu
   input  wire logic       instr_valid,    // one-cycle instruction strobe
   input  wire logic [7:0] instr_opcode,   // executed opcode
   input  wire logic [7:0] acc,            // accumulator value
   input  wire logic       p2_wr,          // cpu writes port 2
   input  wire logic [7:0] p2_wr_data,     // port 2 write value
   output logic [7:0]      p2_rd_data,     // port 2 as seen by cpu
   input  wire logic       cpu_out_wr,     // cpu loads output buffer
   input  wire logic [7:0] cpu_out_data,   // output buffer byte
   output logic            cpu_in_valid,   // input byte waiting
   input  wire logic       cpu_in_ready,   // cpu takes input byte
   output logic [7:0]      cpu_in_data,    // input byte
   output logic            cpu_in_is_cmd,  // byte was a command
   output logic [7:0]      host_status,    // status register copy
   // port 2 pins
   input  wire logic [7:0] p2_in,          // port 2 pin levels
   output logic [7:0]      p2_out          // port 2 drive levels
);
   typedef struct packed {
      logic       rd_n_d;      // previous strobe levels
      logic       wr_n_d;
      logic       cs_n_d;
      logic       a0_d;
      logic       dma_acknowledge_in_d;
      logic [7:0] din_d;
      logic [7:0] out_buf;
      logic       output_buffer_full;
      logic       cmd_flag;
      logic [3:0] usr;
      logic [3:0] usr_pend;
      logic       usr_pend_v;
      logic [7:0] out_pend;
      logic       out_pend_v;
      logic       flags_en;
      logic       dma_en;
      logic       dma_request_out;
      logic       gate_en;
      logic       gate;
      logic       d1_seen;
      logic       seq_done;
      logic [7:0] p2_latch;
      logic [7:0] p2_drv;
      logic [7:0] dout;
      logic       dout_oe;
   } shp_st_t;

   shp_st_t    st_reg;
   shp_st_t    st_next;
   logic       fifo_push;
   logic       fifo_ready;
   logic [8:0] fifo_out;
   logic       input_buffer_full;
   logic       dma_acknowledge_in;
   logic       sel_now;
   logic       wr_end;
   logic       rd_end;
   logic       sel_data;
   logic       sel_any;
   logic       stat_lock;
   logic       op_hit;
   logic [7:0] status_now;

   ////////////////////////////////////////////////////////////////////////////
   // host side decode

   assign dma_acknowledge_in     = st_reg.dma_en & ~p2_in[shp_pkg::P2_DMA_ACKNOWLEDGE_IN];
   assign sel_now  = ~cs_n | dma_acknowledge_in;                                  // [R11]
   // trailing edge seen as soon as the strobe rises, against its level registered at the last edge
   assign wr_end   = ~st_reg.wr_n_d & wr_n;                         // [R3]
   assign rd_end   = ~st_reg.rd_n_d & rd_n;                         // [R3]
   assign sel_any  = ~st_reg.cs_n_d | st_reg.dma_acknowledge_in_d;
   // acknowledge always reaches a data buffer whatever the select line says
   assign sel_data = st_reg.dma_acknowledge_in_d | (~st_reg.cs_n_d & ~st_reg.a0_d); // [R11]
   assign stat_lock = ~rd_n & ~cs_n & command_data_select & ~dma_acknowledge_in;  // [R4]
   assign op_hit   = instr_valid;
   assign input_buffer_full      = cpu_in_valid;

   assign status_now = {st_reg.usr, st_reg.cmd_flag, 1'b0, input_buffer_full, st_reg.output_buffer_full};

   ////////////////////////////////////////////////////////////////////////////
   // host input path

   shp_fifo #(
      .W (shp_pkg::FIFO_WIDTH),
      .D (shp_pkg::FIFO_DEPTH)
   ) u_in_fifo (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .in_valid  (fifo_push),
      .in_ready  (fifo_ready),
      .in_data   ({~sel_data, st_reg.din_d}),
      .out_valid (cpu_in_valid),
      .out_ready (cpu_in_ready),
      .out_data  (fifo_out)
   );                                                               // [R1]

   assign cpu_in_data   = fifo_out[7:0];
   assign cpu_in_is_cmd = fifo_out[8];
   assign host_in_ready = fifo_ready;

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_next   = st_reg;
      fifo_push = 1'b0;

      st_next.rd_n_d = rd_n;
      st_next.wr_n_d = wr_n;
      st_next.cs_n_d = cs_n;
      st_next.a0_d   = command_data_select;
      st_next.dma_acknowledge_in_d = dma_acknowledge_in;
      if (!wr_n) begin
         st_next.din_d = host_din;
      end

      // host write, acted on after the strobe ends
      if (wr_end && sel_any) begin
         if (!sel_data) begin
            if (st_reg.gate_en && st_reg.din_d == shp_pkg::CMD_WRITE_OUT) begin
               st_next.d1_seen  = 1'b1;                             // [R14] [R16] [R19]
               st_next.seq_done = 1'b0;
            end else if (st_reg.seq_done && st_reg.din_d == shp_pkg::CMD_NULL) begin
               st_next.seq_done = 1'b0;                             // [R17]
            end else begin
               // any other command breaks a pending sequence
               fifo_push        = 1'b1;                             // [R18] [R21]
               st_next.cmd_flag = 1'b1;                             // [R21]
               st_next.d1_seen  = 1'b0;                             // [R18]
               st_next.seq_done = 1'b0;
            end
         end else if (st_reg.d1_seen) begin
            st_next.gate     = st_reg.din_d[1];                     // [R13] [R15] [R19]
            st_next.d1_seen  = 1'b0;
            st_next.seq_done = 1'b1;                                // [R16]
         end else begin
            fifo_push        = 1'b1;                                // [R21]
            st_next.cmd_flag = 1'b0;                                // [R21]
            st_next.seq_done = 1'b0;
         end
      end

      // host read of the output buffer clears its flag
      if (rd_end && sel_data) begin
         st_next.output_buffer_full = 1'b0;                                        // [R3]
      end

      // dma request drops on acknowledged strobe
      if ((rd_end || wr_end) && st_reg.dma_acknowledge_in_d) begin
         st_next.dma_request_out = 1'b0;                                        // [R10]
      end

      // cpu loads output buffer; byte and full flag both wait out a status read
      if (cpu_out_wr) begin
         st_next.out_pend   = cpu_out_data;
         st_next.out_pend_v = 1'b1;
      end
      if (st_next.out_pend_v && !stat_lock) begin
         st_next.out_buf    = st_next.out_pend;                     // [R1]
         st_next.output_buffer_full        = 1'b1;                                 // [R4]
         st_next.out_pend_v = 1'b0;
      end

      // instruction decode
      if (op_hit) begin
         case (instr_opcode)
            shp_pkg::OP_STATUS_MOVE: begin
               st_next.usr_pend   = acc[7:4];                       // [R2]
               st_next.usr_pend_v = 1'b1;
            end
            shp_pkg::OP_EN_FLAGS: begin
               st_next.flags_en = 1'b1;                             // [R5]
            end
            shp_pkg::OP_EN_DMA: begin
               st_next.dma_en = 1'b1;                               // [R8]
               st_next.dma_request_out    = 1'b0;                               // [R10]
            end
            shp_pkg::OP_GATE_EN: begin
               st_next.gate_en = 1'b1;                              // [R12] [R20]
            end
            default: begin
               st_next.dma_en = st_next.dma_en;
            end
         endcase
      end
      // user bits land with the move unless a status read holds them back
      if (st_next.usr_pend_v && !stat_lock) begin
         st_next.usr        = st_next.usr_pend;                     // [R2] [R4]
         st_next.usr_pend_v = 1'b0;
      end

      // cpu port 2 write; gate bit is out of the cpu's reach once enabled
      if (p2_wr) begin
         st_next.p2_latch = p2_wr_data;
         if (st_reg.gate_en) begin
            st_next.p2_latch[shp_pkg::P2_GATE] = st_reg.p2_latch[shp_pkg::P2_GATE]; // [R13]
         end
         if (st_next.dma_en && p2_wr_data[shp_pkg::P2_DRQ]) begin
            st_next.dma_request_out = 1'b1;                                     // [R9]
         end
      end

      // pin drive, registered so the pins never glitch, all but bit 5 with flags on
      st_next.p2_drv = st_next.p2_latch;
      if (st_next.gate_en) begin
         st_next.p2_drv[shp_pkg::P2_GATE] = st_next.gate;           // [R13]
      end
      if (st_next.flags_en) begin
         st_next.p2_drv[shp_pkg::P2_OBF] =
            st_next.p2_latch[shp_pkg::P2_OBF] & st_next.output_buffer_full;        // [R6]
      end
      if (st_next.dma_en) begin
         st_next.p2_drv[shp_pkg::P2_DRQ]  = st_next.dma_request_out;            // [R9]
         // acknowledge pin is an input, left weakly high
         st_next.p2_drv[shp_pkg::P2_DMA_ACKNOWLEDGE_IN] = 1'b1;                   // [R8]
      end

      // host read data
      st_next.dout_oe = ~rd_n & sel_now;
      if (command_data_select && !dma_acknowledge_in) begin
         st_next.dout = status_now;
      end else begin
         st_next.dout = st_reg.out_buf;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_reg          <= '0;
         st_reg.rd_n_d   <= 1'b1;
         st_reg.wr_n_d   <= 1'b1;
         st_reg.cs_n_d   <= 1'b1;
         st_reg.usr      <= shp_pkg::USR_RESET;
         st_reg.p2_latch <= shp_pkg::P2_RESET;
         st_reg.p2_drv   <= shp_pkg::P2_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign host_dout    = st_reg.dout;
   assign host_dout_oe = st_reg.dout_oe;
   assign host_status  = status_now;

   always_comb begin
      p2_rd_data = p2_in;
      p2_out     = st_reg.p2_drv;
      if (st_reg.gate_en) begin
         p2_rd_data[shp_pkg::P2_GATE] = st_reg.gate;                // [R13]
      end
      if (st_reg.flags_en) begin
         p2_out[shp_pkg::P2_IBF] = st_reg.p2_latch[shp_pkg::P2_IBF] & ~input_buffer_full; // [R7] pop shows at once
      end
   end
endmodule // shp_host_port

`default_nettype wire

// *** dv/shp_host_port_chk.sv ***
// Purpose: port-level checks of the slave host port
// Assumes: one clock domain, async active-low reset
// Notes:   enable state is tracked from the opcode stream
`timescale 1ns/1ps
`default_nettype none
module shp_host_port_chk (
   input wire logic       clk_sys,             // clock
   input wire logic       reset_n,             // reset, active low
   input wire logic       cs_n,                // chip select
   input wire logic       rd_n,                // read strobe
   input wire logic       wr_n,                // write strobe
   input wire logic       command_data_select, // command or data
   input wire logic       instr_valid,         // opcode strobe
   input wire logic [7:0] instr_opcode,        // opcode
   input wire logic [7:0] acc,                 // accumulator
   input wire logic       p2_wr,               // port write
   input wire logic [7:0] p2_wr_data,          // port write value
   input wire logic [7:0] p2_in,               // port pins in
   input wire logic [7:0] host_status,         // status view
   input wire logic       host_dout_oe,        // bus drive
   input wire logic [7:0] p2_out               // port pins out
);
   logic dma_reg, flg_reg, gate_reg, gate2_reg, b4_reg, b5_reg;
   logic wr_reg, rd_reg, dk_reg, sel_reg;
   wire  lock  = !rd_n && !cs_n && command_data_select;
   wire  w_end = wr_n && !wr_reg;
   wire  s_end = w_end || (rd_n && !rd_reg);
   wire  op_ok = instr_valid;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         {dma_reg, flg_reg, gate_reg, gate2_reg} <= 4'h0;
         {b4_reg, b5_reg, wr_reg, rd_reg, dk_reg, sel_reg} <= 6'h3e;
      end else begin
         // enables never fall back, only reset clears them
         dma_reg   <= dma_reg || (op_ok && instr_opcode == shp_pkg::OP_EN_DMA);
         flg_reg   <= flg_reg || (op_ok && instr_opcode == shp_pkg::OP_EN_FLAGS);
         gate_reg  <= gate_reg || (op_ok && instr_opcode == shp_pkg::OP_GATE_EN);
         gate2_reg <= gate_reg;
         b4_reg    <= p2_wr ? p2_wr_data[4] : b4_reg;
         b5_reg    <= p2_wr ? p2_wr_data[5] : b5_reg;
         {wr_reg, rd_reg, dk_reg, sel_reg} <= {wr_n, rd_n, p2_in[7], command_data_select};
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   property p_move;
      op_ok && instr_opcode == shp_pkg::OP_STATUS_MOVE && !lock |=> host_status[7:4] == $past(acc[7:4]);
   endproperty
   a_move: assert property (p_move) else $error("status move lost");
   property p_lock;
      lock [*3] |-> $stable(host_status[7:4]);
   endproperty
   a_lock: assert property (p_lock) else $error("status changed during read");
   property p_plain;
      !flg_reg && !dma_reg && p2_wr |=> p2_out[7:4] == $past(p2_wr_data[7:4]);
   endproperty
   a_plain: assert property (p_plain) else $error("port bits not plain");
   property p_obf_pin;
      flg_reg |-> p2_out[4] == (b4_reg && host_status[0]);
   endproperty
   a_obf_pin: assert property (p_obf_pin) else $error("out full pin wrong");
   property p_ibf_pin;
      flg_reg |-> p2_out[5] == (b5_reg && !host_status[1]);
   endproperty
   a_ibf_pin: assert property (p_ibf_pin) else $error("in full pin wrong");
   property p_drq;
      dma_reg && p2_wr && p2_wr_data[6] |=> p2_out[6];
   endproperty
   a_drq: assert property (p_drq) else $error("request not raised");
   property p_drop;
      dma_reg && s_end && !dk_reg && !p2_wr |=> !p2_out[6];
   endproperty
   a_drop: assert property (p_drop) else $error("request not dropped");
   property p_gate_hold;
      gate2_reg && !w_end |=> $stable(p2_out[1]);
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("gate pin moved");
   property p_cmd_hold;
      gate2_reg && w_end && sel_reg |=> $stable(p2_out[1]);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("gate pin moved on command");
   property p_oe;
      !rd_n && (!cs_n || (dma_reg && !p2_in[7])) |=> host_dout_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("read data not driven");
   c_lock: cover property (lock [*3]);
   c_gate: cover property (gate2_reg && w_end && !sel_reg);
   c_dma: cover property (dma_reg && s_end && !dk_reg);
endmodule // shp_host_port_chk
bind shp_host_port shp_host_port_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
   .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .command_data_select(command_data_select),
   .instr_valid(instr_valid), .instr_opcode(instr_opcode), .acc(acc), .p2_wr(p2_wr),
   .p2_wr_data(p2_wr_data), .p2_in(p2_in), .host_status(host_status),
   .host_dout_oe(host_dout_oe), .p2_out(p2_out));
`default_nettype wire

// *** dv/shp_host_model.sv ***
// Purpose: host processor and dma controller on the host bus
// Assumes: strobes change 2 ns after a clock edge
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module shp_host_model (
   input  wire logic       clk_sys,   // clock
   input  wire logic [7:0] host_dout, // read data
   output logic            cs_n,      // chip select
   output logic            rd_n,      // read strobe
   output logic            wr_n,      // write strobe
   output logic            sel,       // command or data
   output logic [7:0]      din,       // write data
   output logic            dma_acknowledge_in_n     // dma acknowledge
);
   initial begin
      {cs_n, rd_n, wr_n, sel, dma_acknowledge_in_n} = 5'h1d;
      din = 8'h00;
   end
   task automatic xfer(input logic w, input logic s, input logic dma, input logic [7:0] d,
                       input int hold, output logic [7:0] q);
      @(posedge clk_sys);
      #2;
      sel = s;
      din = w ? d : ~din;
      cs_n = dma;
      dma_acknowledge_in_n = !dma;
      wr_n = !w;
      rd_n = w;
      repeat (hold) @(posedge clk_sys);
      q = host_dout;
      #2;
      {cs_n, rd_n, wr_n, dma_acknowledge_in_n} = 4'hf;
      din = ~din;
      repeat (2) @(posedge clk_sys);
      #2;
   endtask
endmodule // shp_host_model
`default_nettype wire

// *** dv/shp_host_port_tb.sv ***
// Purpose: self-checking bench for the slave host port
// Assumes: host model drives the bus, bench plays the internal cpu
// Notes:   popped input bytes are compared with a queue of notes
`timescale 1ns/1ps
`default_nettype none
module shp_host_port_tb;
   logic        clk_sys, reset_n, instr_valid, p2_wr, cpu_out_wr, cpu_in_ready, stall, pin;
   logic [7:0]  instr_opcode, acc, p2_wr_data, cpu_out_data, q, d, host_dout, p2_rd_data;
   logic [7:0]  host_status, p2_out, cpu_in_data, din;
   logic        host_dout_oe, host_in_ready, cpu_in_valid, cpu_in_is_cmd;
   logic        cs_n, rd_n, wr_n, sel, dma_acknowledge_in_n;
   logic [3:0]  usr;
   logic [8:0]  expq[$];
   logic [11:0] seqt [13];
   int          n_fail, checked, seed, i;
   wire  [7:0]  p2_in = {dma_acknowledge_in_n, 7'h7f};
   shp_host_port uut (.clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .command_data_select(sel), .host_din(din), .host_dout(host_dout),
      .host_dout_oe(host_dout_oe), .host_in_ready(host_in_ready), .instr_valid(instr_valid),
      .instr_opcode(instr_opcode), .acc(acc), .p2_wr(p2_wr), .p2_wr_data(p2_wr_data),
      .p2_rd_data(p2_rd_data), .cpu_out_wr(cpu_out_wr), .cpu_out_data(cpu_out_data),
      .cpu_in_valid(cpu_in_valid), .cpu_in_ready(cpu_in_ready), .cpu_in_data(cpu_in_data),
      .cpu_in_is_cmd(cpu_in_is_cmd), .host_status(host_status), .p2_in(p2_in), .p2_out(p2_out));
   shp_host_model m (.clk_sys(clk_sys), .host_dout(host_dout), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .sel(sel), .din(din), .dma_acknowledge_in_n(dma_acknowledge_in_n));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic pulse(input int k, input logic [7:0] v);
      @(posedge clk_sys);
      #2;
      case (k)
         0: instr_opcode = v;
         1: p2_wr_data = v;
         default: cpu_out_data = v;
      endcase
      {instr_valid, p2_wr, cpu_out_wr} = {k == 0, k == 1, k == 2};
      @(posedge clk_sys);
      #2;
      {instr_valid, p2_wr, cpu_out_wr} = 3'h0;
   endtask
   task automatic hw(input logic s, input logic dma, input logic [7:0] v, input logic push);
      if (push) expq.push_back({s, v});
      m.xfer(1'b1, s, dma, v, 2, q);
   endtask
   task automatic drain;
      repeat (300) if (expq.size() != 0) @(posedge clk_sys);
      chk(16'(expq.size()), 16'h0000);
   endtask
   // drain is random so fifo fill level varies between runs of traffic
   always @(posedge clk_sys) cpu_in_ready <= #2 stall ? 1'b0 : 1'($random(seed));
   always @(posedge clk_sys)
      if (reset_n === 1'b1 && cpu_in_valid === 1'b1 && cpu_in_ready === 1'b1)
         chk({cpu_in_is_cmd, cpu_in_data}, expq.size() ? expq.pop_front() : 9'hxxx);
   initial begin
      #1000000;
      n_fail++;
      stop_test();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'hb375;
      {instr_valid, p2_wr, cpu_out_wr, stall, reset_n} = 5'h02;
      {instr_opcode, acc, p2_wr_data, cpu_out_data} = 32'h00000000;
      seqt = '{12'h9d1, 12'h4df, 12'h9ff, 12'h9d1, 12'h0dd, 12'h9ff, 12'h9d1,
               12'h9d1, 12'h4df, 12'h9ff, 12'h9d1, 12'hb12, 12'hadd};
      repeat (6) @(posedge clk_sys);
      #2;
      reset_n = 1'b1;
      chk({host_status, p2_out}, 16'h00ff);
      pulse(1, 8'h5a);
      chk(p2_out, 8'h5a);
      pulse(1, 8'hff);
      stall = 1'b0;
      for (i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         hw(d[0], 1'b0, d, 1'b1);
         chk(host_status[3], d[0]);
      end
      drain();
      stall = 1'b1;
      for (i = 0; i < 17; i++) hw(1'b0, 1'b0, 8'(i), i < 16);
      chk(host_in_ready, 1'b0);
      stall = 1'b0;
      drain();
      acc = 8'($random(seed));
      pulse(0, shp_pkg::OP_STATUS_MOVE);
      chk(host_status, {acc[7:4], 4'h0});
      usr = acc[7:4];
      fork
         m.xfer(1'b0, 1'b1, 1'b0, 8'h00, 8, q);
         begin
            repeat (2) @(posedge clk_sys);
            #2;
            acc = ~acc;
            pulse(0, shp_pkg::OP_STATUS_MOVE);
            chk(host_status[7:4], usr);
         end
      join
      chk({q[7:4], host_status[7:4]}, {usr, acc[7:4]});
      d = 8'($random(seed));
      pulse(2, d);
      chk(host_status[0], 1'b1);
      m.xfer(1'b0, 1'b0, 1'b0, 8'h00, 2, q);
      chk({q, host_status[0]}, {d, 1'b0});
      stall = 1'b1;
      pulse(0, shp_pkg::OP_EN_FLAGS);
      chk(p2_out[5:4], 2'h2);
      hw(1'b0, 1'b0, d, 1'b1);
      pulse(2, d);
      chk(p2_out[5:4], 2'h1);
      pulse(1, 8'hcf);
      chk(p2_out[5:4], 2'h0);
      m.xfer(1'b0, 1'b0, 1'b0, 8'h00, 2, q);
      stall = 1'b0;
      drain();
      pulse(0, shp_pkg::OP_EN_DMA);
      pulse(1, 8'hff);
      chk(p2_out[6], 1'b1);
      hw(1'b0, 1'b1, d, 1'b1);
      chk(p2_out[6], 1'b0);
      pulse(1, 8'hff);
      pulse(0, shp_pkg::OP_EN_DMA);
      chk(p2_out[6], 1'b0);
      pulse(1, 8'hff);
      pulse(2, d);
      m.xfer(1'b0, 1'b0, 1'b1, 8'h00, 2, q);
      chk({q, p2_out[6]}, {d, 1'b0});
      drain();
      pulse(1, 8'hfd);
      chk(p2_out[1], 1'b0);
      pulse(0, shp_pkg::OP_GATE_EN);
      stall = 1'b1;
      pin = 1'bx;
      for (i = 0; i < 13; i++) begin
         hw(seqt[i][8], 1'b0, seqt[i][7:0], seqt[i][9]);
         if (seqt[i][11:10] != 2'h2) pin = seqt[i][10];
         if (pin !== 1'bx) chk(p2_out[1], pin);
         chk(host_status[1], i > 10);
      end
      pulse(1, 8'h00);
      chk({p2_out[1], p2_rd_data[1]}, 2'h3);
      stall = 1'b0;
      drain();
      hw(1'b1, 1'b0, 8'hff, 1'b1);
      drain();
      stop_test();
   end
endmodule // shp_host_port_tb
`default_nettype wire
